//--- rtl/mirqs_top.sv
// maskable request status and priority block with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none

module mirqs_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [mirqs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [mirqs_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [mirqs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [mirqs_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // peripheral request lines, same clock
    input wire logic [mirqs_pkg::NUM_LINES-1:0] irq_req,
    // external non-maskable request pin, active high
    input wire logic nmi_req,
    // processor core side
    output logic core_irq,
    output logic nmi_to_core,
    input wire logic core_ack,
    output logic [7:0] core_vector,
    // block event interrupt
    output logic evt_irq
);

    // ========================================================================
    // helpers

    // word select shared by read and write decode
    function automatic logic is_reg(input logic [mirqs_pkg::ADDR_W-1:0] addr,
                                    input logic [mirqs_pkg::ADDR_W-1:0] off);
        is_reg = (addr[mirqs_pkg::ADDR_W-1:2] == off[mirqs_pkg::ADDR_W-1:2]);
    endfunction

    // any address that holds a register
    function automatic logic is_mapped(input logic [mirqs_pkg::ADDR_W-1:0] addr);
        is_mapped = is_reg(addr, mirqs_pkg::OFF_VECTOR) || is_reg(addr, mirqs_pkg::OFF_EN_LOW) ||
                    is_reg(addr, mirqs_pkg::OFF_EN_HIGH) || is_reg(addr, mirqs_pkg::OFF_STAT_LOW) ||
                    is_reg(addr, mirqs_pkg::OFF_STAT_HIGH) || is_reg(addr, mirqs_pkg::OFF_EVT_STATUS) ||
                    is_reg(addr, mirqs_pkg::OFF_EVT_MASK);
    endfunction

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = data[15:8];
        end
    endfunction

    // ========================================================================
    // declarations
    logic [mirqs_pkg::NUM_LINES-1:0] source_active_bits_q;
    logic [mirqs_pkg::HALF_W-1:0] source_enable_low_q;
    logic [mirqs_pkg::HALF_W-1:0] source_enable_high_q;
    logic [mirqs_pkg::NUM_LINES-1:0] source_enable_bits;
    logic [mirqs_pkg::NUM_LINES-1:0] pending;
    logic [mirqs_pkg::IDX_W-1:0] win_idx;
    logic win_valid;
    logic [7:0] winning_vector_field_d;
    logic [7:0] winning_vector_reg_q;
    logic nmi_s1_q;
    logic nmi_s2_q;
    logic nmi_rise;
    logic [mirqs_pkg::EVT_W-1:0] evt_set;
    logic [mirqs_pkg::EVT_W-1:0] evt_clr;
    logic [mirqs_pkg::EVT_W-1:0] evt_mask_q;
    logic [mirqs_pkg::EVT_W-1:0] evt_status;
    logic [mirqs_pkg::ADDR_W-1:0] aw_addr_q;
    logic [mirqs_pkg::DATA_W-1:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic [mirqs_pkg::DATA_W-1:0] rd_data_d;
    logic rd_err_d;

    // ========================================================================
    // request sampling
    // sample every edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_active_bits_q <= '0;
        end else begin
            source_active_bits_q <= irq_req & mirqs_pkg::LINE_USED;
        end
    end

    // ========================================================================
    // priority and vector
    // only enabled requesters compete
    always_comb begin
        source_enable_bits = {source_enable_high_q, source_enable_low_q[15:1], 1'b0};
        pending = source_active_bits_q & source_enable_bits;
    end

    mirqs_prio_enc #(
        .W(mirqs_pkg::NUM_LINES),
        .IW(mirqs_pkg::IDX_W)
    ) u_prio (
        .req(pending),
        .idx(win_idx),
        .valid(win_valid)
    );

    always_comb begin
        winning_vector_field_d = mirqs_pkg::VEC_BASE + {3'h0, win_idx};
    end

    // vector tracks the winner every cycle; an ack with no winner reads the base value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            winning_vector_reg_q <= mirqs_pkg::VEC_BASE;
            core_vector <= mirqs_pkg::VEC_BASE;
        end else begin
            winning_vector_reg_q <= winning_vector_field_d;
            core_vector <= winning_vector_field_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_irq <= 1'b0;
        end else begin
            core_irq <= win_valid;
        end
    end

    // ========================================================================
    // non-maskable path
    // the pin is asynchronous, so it crosses two flops before anything looks at it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
        end else begin
            nmi_s1_q <= nmi_req;
            nmi_s2_q <= nmi_s1_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_to_core <= 1'b0;
        end else begin
            nmi_to_core <= nmi_s2_q;
        end
    end

    // ========================================================================
    // block events
    always_comb begin
        nmi_rise = nmi_s2_q && !nmi_to_core;
        evt_set = '0;
        evt_set[mirqs_pkg::EVT_SPURIOUS] = core_ack && !win_valid;
        evt_set[mirqs_pkg::EVT_NMI] = nmi_rise;
        evt_clr = '0;
        if (wr_go && is_reg(aw_addr_q, mirqs_pkg::OFF_EVT_STATUS) && w_strb_q[0]) begin
            evt_clr = w_data_q[mirqs_pkg::EVT_W-1:0];
        end
    end

    mirqs_sticky #(
        .W(mirqs_pkg::EVT_W)
    ) u_evt (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(evt_set),
        .clr(evt_clr),
        .mask(evt_mask_q),
        .status_q(evt_status),
        .irq_q(evt_irq)
    );

    // ========================================================================
    // axi write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // both halves held and no response outstanding
    always_comb begin
        wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    end

    // response; read-only words accept and ignore, holes answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mirqs_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_addr_q) ? mirqs_pkg::RESP_OKAY : mirqs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_enable_low_q <= mirqs_pkg::EN_RESET;
            source_enable_high_q <= mirqs_pkg::EN_RESET;
        end else if (wr_go) begin
            if (is_reg(aw_addr_q, mirqs_pkg::OFF_EN_LOW)) begin
                source_enable_low_q <= merge16(source_enable_low_q, w_data_q, w_strb_q);
            end
            if (is_reg(aw_addr_q, mirqs_pkg::OFF_EN_HIGH)) begin
                source_enable_high_q <= merge16(source_enable_high_q, w_data_q, w_strb_q);
            end
        end
    end

    // event mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_mask_q <= mirqs_pkg::EVT_MASK_RESET;
        end else if (wr_go && is_reg(aw_addr_q, mirqs_pkg::OFF_EVT_MASK) && w_strb_q[0]) begin
            evt_mask_q <= w_data_q[mirqs_pkg::EVT_W-1:0];
        end
    end

    // ========================================================================
    // axi read channel
    // read data select for every register word
    // request status words have no write path; event status clears by writing ones
    always_comb begin
        rd_data_d = '0;
        rd_err_d = 1'b0;
        if (is_reg(s_axi_araddr, mirqs_pkg::OFF_VECTOR)) begin
            rd_data_d[7:0] = winning_vector_reg_q;
        end else if (is_reg(s_axi_araddr, mirqs_pkg::OFF_EN_LOW)) begin
            rd_data_d[15:0] = source_enable_low_q;
        end else if (is_reg(s_axi_araddr, mirqs_pkg::OFF_EN_HIGH)) begin
            rd_data_d[15:0] = source_enable_high_q;
        end else if (is_reg(s_axi_araddr, mirqs_pkg::OFF_STAT_LOW)) begin
            rd_data_d[15:0] = {source_active_bits_q[15:1], 1'b0};
        end else if (is_reg(s_axi_araddr, mirqs_pkg::OFF_STAT_HIGH)) begin
            rd_data_d[15:0] = source_active_bits_q[31:16];
        end else if (is_reg(s_axi_araddr, mirqs_pkg::OFF_EVT_STATUS)) begin
            rd_data_d[mirqs_pkg::EVT_W-1:0] = evt_status;
        end else if (is_reg(s_axi_araddr, mirqs_pkg::OFF_EVT_MASK)) begin
            rd_data_d[mirqs_pkg::EVT_W-1:0] = evt_mask_q;
        end else begin
            rd_err_d = 1'b1;
        end
    end

    // one read at a time; data answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= mirqs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_d;
            s_axi_rresp <= rd_err_d ? mirqs_pkg::RESP_SLVERR : mirqs_pkg::RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================================================
    // checks
    sequence s_rd_at(logic [mirqs_pkg::ADDR_W-1:0] off);
        s_axi_arvalid && s_axi_arready && is_reg(s_axi_araddr, off);
    endsequence

    sequence s_answer;
        ##1 s_axi_rvalid;
    endsequence

    property p_raw_status;
        @(posedge aclk) disable iff (!aresetn)
        ##1 source_active_bits_q == ($past(irq_req) & mirqs_pkg::LINE_USED);
    endproperty
    a_raw_status: assert property (p_raw_status) else $error("status not raw sample");

    property p_stat_low;
        @(posedge aclk) disable iff (!aresetn)
        s_rd_at(mirqs_pkg::OFF_STAT_LOW)
        |-> s_answer ##0 (s_axi_rdata == {16'h0000, $past(source_active_bits_q[15:1]), 1'b0});
    endproperty
    a_stat_low: assert property (p_stat_low) else $error("low status read wrong");

    property p_bit0_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_rd_at(mirqs_pkg::OFF_STAT_LOW) |=> !s_axi_rdata[0];
    endproperty
    a_bit0_zero: assert property (p_bit0_zero) else $error("status bit 0 not zero");

    property p_stat_high;
        @(posedge aclk) disable iff (!aresetn)
        s_rd_at(mirqs_pkg::OFF_STAT_HIGH) |=> s_axi_rdata == {16'h0000, $past(source_active_bits_q[31:16])};
    endproperty
    a_stat_high: assert property (p_stat_high) else $error("high status read wrong");

    property p_ro_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && (is_reg(aw_addr_q, mirqs_pkg::OFF_STAT_LOW) || is_reg(aw_addr_q, mirqs_pkg::OFF_STAT_HIGH))
        |=> $stable(source_enable_low_q) && $stable(source_enable_high_q) && s_axi_bresp == mirqs_pkg::RESP_OKAY;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("status write had effect");

    property p_top_wins;
        @(posedge aclk) disable iff (!aresetn)
        pending[31] |=> winning_vector_reg_q == mirqs_pkg::VEC_TOP;
    endproperty
    a_top_wins: assert property (p_top_wins) else $error("line 31 did not win");

    property p_nmi_pass;
        @(posedge aclk) disable iff (!aresetn)
        $rose(nmi_req) ##1 nmi_req [*2] |=> nmi_to_core;
    endproperty
    a_nmi_pass: assert property (p_nmi_pass) else $error("nmi not passed");

    property p_core_req;
        @(posedge aclk) disable iff (!aresetn)
        (|pending) |=> core_irq ##0 (core_vector > mirqs_pkg::VEC_BASE);
    endproperty
    a_core_req: assert property (p_core_req) else $error("core request missing");

    property p_vec_range;
        @(posedge aclk) disable iff (!aresetn)
        ##1 core_vector == mirqs_pkg::VEC_BASE + {3'h0, $past(win_idx)} && core_vector <= mirqs_pkg::VEC_TOP;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector encoding wrong");

    property p_disabled_ignored;
        @(posedge aclk) disable iff (!aresetn)
        (source_active_bits_q != '0) && (pending == '0) |=> !core_irq && core_vector == mirqs_pkg::VEC_BASE;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled source won");

    property p_en_reset;
        @(posedge aclk)
        !aresetn |=> source_enable_low_q == mirqs_pkg::EN_RESET && source_enable_high_q == mirqs_pkg::EN_RESET;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enables not all ones");

    property p_stat_reset;
        @(posedge aclk)
        !aresetn |=> source_active_bits_q == '0;
    endproperty
    a_stat_reset: assert property (p_stat_reset) else $error("status not clear after reset");

    property p_evt_irq;
        @(posedge aclk) disable iff (!aresetn)
        ##1 evt_irq == |(evt_status & $past(evt_mask_q));
    endproperty
    a_evt_irq: assert property (p_evt_irq) else $error("event interrupt wrong");

endmodule

`default_nettype wire

//--- rtl/mirqs_pkg.sv
// package: register map, reset values and line assignment for the maskable request status block
package mirqs_pkg;

    // ========================================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_LINES = 32;
    localparam int IDX_W = 5;
    localparam int HALF_W = 16;

    // ========================================================================
    // register byte offsets (one aligned word each)
    localparam logic [ADDR_W-1:0] OFF_VECTOR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_EN_LOW = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_EN_HIGH = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STAT_LOW = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STAT_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h18;

    // ========================================================================
    // reset values and encodings
    localparam logic [HALF_W-1:0] EN_RESET = 16'hffff;
    localparam logic [HALF_W-1:0] STAT_RESET = 16'h0000;
    localparam logic [7:0] VEC_BASE = 8'h10;
    localparam logic [7:0] VEC_TOP = 8'h2f;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ========================================================================
    // event bits of the sticky status / mask registers
    localparam int EVT_W = 2;
    localparam int EVT_SPURIOUS = 0;
    localparam int EVT_NMI = 1;
    localparam logic [EVT_W-1:0] EVT_MASK_RESET = 2'h0;

    // ========================================================================
    // request lines with no source behind them
    localparam int LINE_NONE0 = 0;
    localparam int LINE_RSVD19 = 19;
    localparam logic [NUM_LINES-1:0] LINE_USED = ~((32'h1 << LINE_NONE0) | (32'h1 << LINE_RSVD19));

endpackage

//--- rtl/mirqs_prio_enc.sv
// fixed linear priority encoder: the highest set index wins
`timescale 1ns/1ps
`default_nettype none

module mirqs_prio_enc #(
    parameter int W = 32,
    parameter int IW = 5
) (
    // candidates
    input wire logic [W-1:0] req,
    // winner
    output logic [IW-1:0] idx,
    output logic valid
);

    // ========================================================================
    // later iterations override, so the top index has the last word
    always_comb begin
        idx = '0;
        valid = 1'b0;
        for (int i = 0; i < W; i++) begin
            if (req[i]) begin
                idx = i[IW-1:0];
                valid = 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

//--- rtl/mirqs_sticky.sv
// sticky event bits with write-one-to-clear and a masked level interrupt
`timescale 1ns/1ps
`default_nettype none

module mirqs_sticky #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // events and software clear
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] mask,
    // state
    output logic [W-1:0] status_q,
    output logic irq_q
);

    logic [W-1:0] status_d;

    // ========================================================================
    // set wins over clear so an event in the clearing cycle survives
    always_comb begin
        status_d = (status_q & ~clr) | set;
    end

    // status bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // level interrupt, registered from the next status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & mask);
        end
    end

endmodule

`default_nettype wire

//--- testbench/mirqs_core_model.sv
// processor core model: acknowledge cycles on command
`timescale 1ns/1ps
`default_nettype none
module mirqs_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // block side
    input wire logic [7:0] core_vector,
    output logic core_ack,
    // bench command and captured vector
    input wire logic ack_cmd,
    output logic [7:0] vec_q
);
    // ========================================
    // nesting stays off
    // no ack of its own: the handler never re-enables, so ack only on command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ack <= 1'b0;
        end else begin
            core_ack <= ack_cmd & ~core_ack;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_q <= 8'h00;
        end else if (core_ack) begin
            vec_q <= core_vector;
        end
    end
endmodule
`default_nettype wire

//--- testbench/maskable_irq_status_priority_tb.sv
// testbench: register bus, request status, priority and event checks
`timescale 1ns/1ps
`default_nettype none
module maskable_irq_status_priority_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, core_vector, vec_q;
    logic [31:0] s_axi_wdata = 32'h0, irq_req = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nmi_req = 1'b0, ack_cmd = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic core_irq, nmi_to_core, core_ack, evt_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, br;
    int mismatches = 0, checked = 0;
    // ========================================
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    mirqs_top u_mirqs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req,
        .nmi_req, .core_irq, .nmi_to_core, .core_ack, .core_vector, .evt_irq);
    mirqs_core_model u_mirqs_core_model (.aclk, .aresetn, .core_vector, .core_ack, .ack_cmd, .vec_q);
    // ========================================
    // compare and bus tasks; ready is sampled at negedge, stable until the taking edge
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("Error %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ka, kw, kb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ka = s_axi_awvalid & s_axi_awready;
            kw = s_axi_wvalid & s_axi_wready;
            kb = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge aclk);
            if (ka) s_axi_awvalid <= 1'b0;
            if (kw) s_axi_wvalid <= 1'b0;
        end while (!kb);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ka, kr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ka = s_axi_arvalid & s_axi_arready;
            kr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ka) s_axi_arvalid <= 1'b0;
        end while (!kr);
        s_axi_rready <= 1'b0;
        chk(d, e);
        chk(r, er);
    endtask
    task automatic settle();
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask
    // ========================================
    // scenarios
    task automatic t_reset();
        rchk(mirqs_pkg::OFF_EN_LOW, 32'hffff, mirqs_pkg::RESP_OKAY);
        rchk(mirqs_pkg::OFF_EN_HIGH, 32'hffff, mirqs_pkg::RESP_OKAY);
        rchk(mirqs_pkg::OFF_STAT_LOW, 32'h0, mirqs_pkg::RESP_OKAY);
        rchk(mirqs_pkg::OFF_STAT_HIGH, 32'h0, mirqs_pkg::RESP_OKAY);
        rchk(mirqs_pkg::OFF_VECTOR, 32'h10, mirqs_pkg::RESP_OKAY);
        rchk(8'h40, 32'h0, mirqs_pkg::RESP_SLVERR);
    endtask
    // lines 0..i all requesting: status shows each used line, i wins unless reserved
    task automatic t_prio();
        for (int i = 1; i < 32; i++) begin
            @(posedge aclk);
            irq_req <= 32'hffffffff >> (31 - i);
            settle();
            chk(core_vector, 8'h10 + (i == 19 ? 18 : i));
            chk(core_irq, 1'b1);
            rchk(mirqs_pkg::OFF_STAT_LOW, (32'hffff >> (15 - (i > 15 ? 15 : i))) & 32'hfffe, 2'b00);
            rchk(mirqs_pkg::OFF_STAT_HIGH, i < 16 ? 32'h0 : (32'hffff >> (31 - i)) & 32'hfff7, 2'b00);
        end
    endtask
    task automatic t_mask();
        // exclusions before nesting: software drops the top source first
        wr(mirqs_pkg::OFF_EN_HIGH, 32'h7fff);
        settle();
        chk(core_vector, 8'h2e);
        wr(mirqs_pkg::OFF_EN_HIGH, 32'h0);
        rchk(mirqs_pkg::OFF_VECTOR, 32'h1f, 2'b00);
        wr(mirqs_pkg::OFF_EN_LOW, 32'h1);
        wr(mirqs_pkg::OFF_STAT_LOW, 32'h0);
        chk(br, mirqs_pkg::RESP_OKAY);
        settle();
        chk(core_irq, 1'b0);
        rchk(mirqs_pkg::OFF_STAT_LOW, 32'hfffe, 2'b00);
        rchk(mirqs_pkg::OFF_STAT_HIGH, 32'hfff7, 2'b00);
    endtask
    task automatic ack();
        @(posedge aclk);
        ack_cmd <= 1'b1;
        @(posedge aclk);
        ack_cmd <= 1'b0;
        settle();
    endtask
    // spurious ack raises an event; mask, interrupt and clear; then a real ack
    task automatic t_evt();
        irq_req <= 32'h0;
        settle();
        ack();
        chk(vec_q, 8'h10);
        rchk(mirqs_pkg::OFF_EVT_STATUS, 32'h1, 2'b00);
        chk(evt_irq, 1'b0);
        wr(mirqs_pkg::OFF_EVT_MASK, 32'h3);
        @(negedge aclk);
        chk(evt_irq, 1'b1);
        wr(mirqs_pkg::OFF_EVT_STATUS, 32'h1);
        settle();
        chk(evt_irq, 1'b0);
        wr(mirqs_pkg::OFF_EN_LOW, 32'hffff);
        irq_req <= 32'h20;
        settle();
        ack();
        chk(vec_q, 8'h15);
    endtask
    task automatic t_nmi();
        int n;
        n = 0;
        @(posedge aclk);
        nmi_req <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            @(negedge aclk);
        end while (!nmi_to_core && n < 8);
        chk(n, 3);
        settle();
        chk(evt_irq, 1'b1);
        rchk(mirqs_pkg::OFF_EVT_STATUS, 32'h2, 2'b00);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_prio();
        t_mask();
        t_evt();
        t_nmi();
        test_done();
    end
    initial begin
        repeat (8000) @(posedge aclk);
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
